// *** src/smlc_params.svh ***
// constants for the serial line modem control block: offsets, fields, resets, timing
// assumes a 200 MHz system clock and a 32-bit classic wishbone register bus
`ifndef SMLC_PARAMS_SVH
`define SMLC_PARAMS_SVH

// register byte offsets, one aligned word each
`define SMLC_OFS_MODE_A   8'h00
`define SMLC_OFS_CFG2_A   8'h04
`define SMLC_OFS_MODE_B   8'h08
`define SMLC_OFS_CFG2_B   8'h0C
`define SMLC_OFS_STATUS   8'h10
`define SMLC_OFS_MASK     8'h14
`define SMLC_OFS_LINE     8'h18
`define SMLC_OFS_CTRL     8'h1C

// field positions
`define SMLC_MODE_RTS_BIT 0
`define SMLC_CTRL_WAKE    0
`define SMLC_LANE0        0
`define SMLC_STS_CTS      0
`define SMLC_STS_COLL     2

// reset values
`define SMLC_MODE_RST     1'h0
`define SMLC_CFG_RST      4'h0
`define SMLC_STS_RST      4'h0
`define SMLC_MASK_RST     4'h0

// timing: serial clock period as a divide of the system clock
`define SMLC_CLK_NS       5
`define SMLC_SER_DIV      16
`define SMLC_RES_MIN_NS   1800
`define SMLC_RES_MIN_CYC  ((`SMLC_RES_MIN_NS + `SMLC_CLK_NS - 1) / `SMLC_CLK_NS)

`endif

// *** src/smlc_pkg.sv ***
// types shared by the serial line modem control block
// holds no constants; those live in smlc_params.svh
package smlc_pkg;

	// how the request-to-send pin is steered
	typedef enum logic [1:0] {
		SMLC_RTS_CTRL,
		SMLC_RTS_TX,
		SMLC_RTS_RX,
		SMLC_RTS_OFF
	} smlc_rts_mode_t;

	// second channel configuration register
	typedef struct packed {
		logic           cts_irq_en;
		logic           open_drain;
		smlc_rts_mode_t rts_mode;
	} smlc_cfg_t;

	// frame engine towards the line logic
	typedef struct packed {
		logic tx_bit;
		logic tx_active;
		logic tx_coll;
		logic tx_pend;
		logic rx_frame;
	} smlc_frame_in_t;

	// line logic towards the frame engine
	typedef struct packed {
		logic rx_bit;
		logic tx_enable;
		logic collision;
	} smlc_frame_out_t;

	// read-only line status word, bit 0 is channel A cts... low fields last
	typedef struct packed {
		logic       power_down;
		logic [1:0] tx_enable;
		logic [1:0] collision;
		logic [1:0] rts_n;
		logic [1:0] cts_n;
	} smlc_line_t;

endpackage

// *** src/smlc_div.sv ***
// serial clock period divider: one-cycle enable pulse every SMLC_SER_DIV clocks
// assumes a single free-running system clock
`timescale 1ns/1ps
`include "smlc_params.svh"

module smlc_div (
	input  wire logic clk,
	input  wire logic nrst,
	output logic      ser_en
);
	logic [7:0] cnt_q;

	// free-running count, restarts on wrap so the pulse is exactly one cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q  <= 8'h00;
			ser_en <= 1'b0;
		end else if (cnt_q == 8'(`SMLC_SER_DIV - 1)) begin
			cnt_q  <= 8'h00;
			ser_en <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 8'h01;
			ser_en <= 1'b0;
		end
	end
endmodule

// *** src/smlc_rts.sv ***
// request-to-send pin control for one channel
// assumes frame status inputs are synchronous to clk; ser_en marks serial periods
`timescale 1ns/1ps
`include "smlc_params.svh"

module smlc_rts (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  srst,
	input  wire logic                  ser_en,
	input  wire logic                  rts_bit,
	input  wire smlc_pkg::smlc_rts_mode_t mode,
	input  wire smlc_pkg::smlc_frame_in_t frame,
	output logic                       rts_n
);
	logic tx_dly_q;

	// transmission shifted by one serial period, collision bits left out
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_dly_q <= 1'b0;
		end else if (srst) begin
			tx_dly_q <= 1'b0;
		end else if (ser_en) begin
			tx_dly_q <= frame.tx_active & ~frame.tx_coll;
		end
	end

	// pin is idle high; low means request to send
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rts_n <= 1'b1;
		end else if (srst) begin
			rts_n <= 1'b1;
		end else begin
			case (mode)
				smlc_pkg::SMLC_RTS_CTRL: begin
					if (rts_bit) begin
						rts_n <= 1'b0;
					end else if (!frame.tx_active && !frame.tx_pend) begin
						rts_n <= 1'b1;
					end
				end
				smlc_pkg::SMLC_RTS_TX: rts_n <= ~tx_dly_q;
				smlc_pkg::SMLC_RTS_RX: rts_n <= ~frame.rx_frame;
				smlc_pkg::SMLC_RTS_OFF: rts_n <= 1'b1;
				default: rts_n <= 1'b1;
			endcase
		end
	end
endmodule

// *** src/smlc_top.sv ***
// line-side modem control for two serial channels with a wishbone register slave
// assumes all pins synchronous to MCLK; frame engine sits outside on the frame ports
//
// Notes on behaviour
// - each channel takes receive data on its own pin, A and B apart.
// - setting the request-to-send bit in a channel mode register drives its rts low.
// - after the bit clears, rts returns high only when transmit is done and none pends.
// - a bus option drives rts low while a frame is sent, one serial period late, less collision bits.
// - a bus option in the second config register drives rts low while a frame is received.
// - a bus option disables request-to-send and holds rts high.
// - a channel transmitter may run only while its cts input is low.
// - when enabled, a change of level on cts raises an interrupt.
// - the transmit pin is push-pull or open-drain by configuration.
`timescale 1ns/1ps
`include "smlc_params.svh"

module smlc_top (
	input  wire logic                     MCLK,
	input  wire logic                     NRST,
	input  wire logic                     RESET_INPUT_PIN,
	input  wire logic                     WB_CYC_I,
	input  wire logic                     WB_STB_I,
	input  wire logic                     WB_WE_I,
	input  wire logic [7:0]               WB_ADR_I,
	input  wire logic [3:0]               WB_SEL_I,
	input  wire logic [31:0]              WB_DAT_I,
	output logic      [31:0]              WB_DAT_O,
	output logic                          WB_ACK_O,
	output logic                          INT_O,
	output logic                          POWER_DOWN,
	input  wire logic                     RECV_SERIAL_IN_A,
	input  wire logic                     RECV_SERIAL_IN_B,
	input  wire logic                     CTS_N_A,
	input  wire logic                     CTS_N_B,
	input  wire logic                     COLLISION_SENSE_IN_A,
	input  wire logic                     COLLISION_SENSE_IN_B,
	output logic                          RTS_N_A,
	output logic                          RTS_N_B,
	output logic                          XMIT_SERIAL_OUT_A,
	output logic                          XMIT_SERIAL_OUT_B,
	output logic                          XMIT_SERIAL_OE_A,
	output logic                          XMIT_SERIAL_OE_B,
	input  wire smlc_pkg::smlc_frame_in_t FRAME_IN_A,
	input  wire smlc_pkg::smlc_frame_in_t FRAME_IN_B,
	output smlc_pkg::smlc_frame_out_t     FRAME_OUT_A,
	output smlc_pkg::smlc_frame_out_t     FRAME_OUT_B
);
	// shared control
	logic                      srst;
	logic                      ser_en;
	logic                      pin_q;
	logic                      pd_q;
	logic                      rd_go;
	logic                      wr_go;
	logic [3:0]                sts_q;
	logic [3:0]                sts_d;
	logic [3:0]                sts_set;
	logic [3:0]                mask_q;
	logic [31:0]               rdata;
	smlc_pkg::smlc_line_t      line;

	// per-channel arrays, index 0 is channel A
	logic                      mode_q    [2];
	smlc_pkg::smlc_cfg_t       cfg_q     [2];
	smlc_pkg::smlc_frame_in_t  fin       [2];
	smlc_pkg::smlc_frame_out_t fout_q    [2];
	logic [1:0]                recv;
	logic [1:0]                cts_n;
	logic [1:0]                csense;
	logic [1:0]                cts_q;
	logic [1:0]                rts_n;
	logic [1:0]                txd_q;
	logic [1:0]                txoe_q;
	logic [1:0]                cts_ev;
	logic [1:0]                coll_ev;

	// reset pin holds the config, status, rts and pin registers in reset, synchronously; bus, divider and cts sample flops run on
	assign srst = RESET_INPUT_PIN;

	assign recv   = {RECV_SERIAL_IN_B, RECV_SERIAL_IN_A};
	assign cts_n  = {CTS_N_B, CTS_N_A};
	assign csense = {COLLISION_SENSE_IN_B, COLLISION_SENSE_IN_A};
	assign fin[0] = FRAME_IN_A;
	assign fin[1] = FRAME_IN_B;

	smlc_div u_div (
		.clk    (MCLK),
		.nrst   (NRST),
		.ser_en (ser_en)
	);

	// bus handshake: ack rises one edge after the strobe and lasts one cycle;
	// the write lands on the edge where the master sees ack
	assign rd_go = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr_go = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[`SMLC_LANE0];

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= rd_go;
		end
	end

	// read data sampled with ack so it is stable for the whole answer cycle
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			WB_DAT_O <= 32'h0000_0000;
		end else if (rd_go) begin
			WB_DAT_O <= rdata;
		end
	end

	// line status word shows the block's own pin state
	always_comb begin
		line.power_down = pd_q;
		line.tx_enable  = {fout_q[1].tx_enable, fout_q[0].tx_enable};
		line.collision  = {fout_q[1].collision, fout_q[0].collision};
		line.rts_n      = rts_n;
		line.cts_n      = cts_q;
	end

	// read mux; unmapped offsets read as zero and are still acknowledged
	always_comb begin
		rdata = 32'h0000_0000;
		case (WB_ADR_I)
			`SMLC_OFS_MODE_A: rdata = {31'h0, mode_q[0]};
			`SMLC_OFS_CFG2_A: rdata = {28'h0, cfg_q[0]};
			`SMLC_OFS_MODE_B: rdata = {31'h0, mode_q[1]};
			`SMLC_OFS_CFG2_B: rdata = {28'h0, cfg_q[1]};
			`SMLC_OFS_STATUS: rdata = {28'h0, sts_q};
			`SMLC_OFS_MASK:   rdata = {28'h0, mask_q};
			`SMLC_OFS_LINE:   rdata = {23'h0, line};
			`SMLC_OFS_CTRL:   rdata = {31'h0, pd_q};
			default:          rdata = 32'h0000_0000;
		endcase
	end

	// powered while the pin is high, power-down once it falls
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= RESET_INPUT_PIN;
		end
	end

	// power-down is left by software writing the wake bit or by the reset pin
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			pd_q <= 1'b0;
		end else if (RESET_INPUT_PIN) begin
			pd_q <= 1'b0;
		end else if (pin_q) begin
			pd_q <= 1'b1;
		end else if (wr_go && WB_ADR_I == `SMLC_OFS_CTRL && WB_DAT_I[`SMLC_CTRL_WAKE]) begin
			pd_q <= 1'b0;
		end
	end

	// pin copy is cleared at once by the reset pin, not one edge later via pd_q
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			POWER_DOWN <= 1'b0;
		end else if (srst) begin
			POWER_DOWN <= 1'b0;
		end else begin
			POWER_DOWN <= pd_q;
		end
	end

	// event bits: cts changes in the low pair, collisions in the high pair
	assign sts_set = {coll_ev, cts_ev};

	// write-one-to-clear; an event in the clearing cycle survives
	always_comb begin
		sts_d = sts_q | sts_set;
		if (wr_go && WB_ADR_I == `SMLC_OFS_STATUS) begin
			sts_d = (sts_q & ~WB_DAT_I[3:0]) | sts_set;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			sts_q <= `SMLC_STS_RST;
		end else if (srst) begin
			sts_q <= `SMLC_STS_RST;
		end else begin
			sts_q <= sts_d;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			mask_q <= `SMLC_MASK_RST;
		end else if (srst) begin
			mask_q <= `SMLC_MASK_RST;
		end else if (wr_go && WB_ADR_I == `SMLC_OFS_MASK) begin
			mask_q <= WB_DAT_I[3:0];
		end
	end

	// level interrupt, registered; follows the status one cycle late
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			INT_O <= 1'b0;
		end else if (srst) begin
			INT_O <= 1'b0;
		end else begin
			INT_O <= |(sts_q & mask_q);
		end
	end

	// one copy of the line logic per channel; bus, divider, power-down and status are shared
	for (genvar i = 0; i < 2; i++) begin : g_ch
		localparam logic [7:0] OFS_MODE = (i == 0) ? `SMLC_OFS_MODE_A : `SMLC_OFS_MODE_B;
		localparam logic [7:0] OFS_CFG  = (i == 0) ? `SMLC_OFS_CFG2_A : `SMLC_OFS_CFG2_B;
		logic tx_bit;

		always_ff @(posedge MCLK or negedge NRST) begin
			if (!NRST) begin
				mode_q[i] <= `SMLC_MODE_RST;
			end else if (srst) begin
				mode_q[i] <= `SMLC_MODE_RST;
			end else if (wr_go && WB_ADR_I == OFS_MODE) begin
				mode_q[i] <= WB_DAT_I[`SMLC_MODE_RTS_BIT];
			end
		end

		always_ff @(posedge MCLK or negedge NRST) begin
			if (!NRST) begin
				cfg_q[i] <= smlc_pkg::smlc_cfg_t'(`SMLC_CFG_RST);
			end else if (srst) begin
				cfg_q[i] <= smlc_pkg::smlc_cfg_t'(`SMLC_CFG_RST);
			end else if (wr_go && WB_ADR_I == OFS_CFG) begin
				cfg_q[i] <= smlc_pkg::smlc_cfg_t'(WB_DAT_I[3:0]);
			end
		end

		smlc_rts u_rts (
			.clk     (MCLK),
			.nrst    (NRST),
			.srst    (srst),
			.ser_en  (ser_en),
			.rts_bit (mode_q[i]),
			.mode    (cfg_q[i].rts_mode),
			.frame   (fin[i]),
			.rts_n   (rts_n[i])
		);

		// idle line is a one whenever the transmitter is not allowed to run
		assign tx_bit = fout_q[i].tx_enable ? fin[i].tx_bit : 1'b1;

		// previous cts level for change detection
		always_ff @(posedge MCLK or negedge NRST) begin
			if (!NRST) begin
				cts_q[i] <= 1'b1;
			end else begin
				cts_q[i] <= cts_n[i];
			end
		end

		// change of cts level, when enabled
		assign cts_ev[i] = cfg_q[i].cts_irq_en & (cts_q[i] ^ cts_n[i]) & ~srst;

		// line low while our pin is released means someone else drives
		// compare against the registered pin, since tx_bit leads the pin by one edge
		assign coll_ev[i] = cfg_q[i].open_drain & fin[i].tx_active & ~txoe_q[i] & ~csense[i]
			& ~srst;

		always_ff @(posedge MCLK or negedge NRST) begin
			if (!NRST) begin
				fout_q[i] <= '0;
			end else if (srst) begin
				fout_q[i] <= '0;
			end else begin
				fout_q[i].rx_bit    <= recv[i];
				fout_q[i].tx_enable <= ~cts_n[i] & ~pd_q;
				fout_q[i].collision <= coll_ev[i];
			end
		end

		// open drain only ever pulls low; push-pull drives except while the reset pin holds both pins released
		always_ff @(posedge MCLK or negedge NRST) begin
			if (!NRST) begin
				txd_q[i]  <= 1'b1;
				txoe_q[i] <= 1'b0;
			end else if (srst) begin
				txd_q[i]  <= 1'b1;
				txoe_q[i] <= 1'b0;
			end else if (cfg_q[i].open_drain) begin
				txd_q[i]  <= 1'b0;
				txoe_q[i] <= ~tx_bit;
			end else begin
				txd_q[i]  <= tx_bit;
				txoe_q[i] <= 1'b1;
			end
		end
	end

	// pins straight from the channel flip-flops
	assign RTS_N_A           = rts_n[0];
	assign RTS_N_B           = rts_n[1];
	assign XMIT_SERIAL_OUT_A = txd_q[0];
	assign XMIT_SERIAL_OUT_B = txd_q[1];
	assign XMIT_SERIAL_OE_A  = txoe_q[0];
	assign XMIT_SERIAL_OE_B  = txoe_q[1];
	assign FRAME_OUT_A       = fout_q[0];
	assign FRAME_OUT_B       = fout_q[1];
endmodule

// *** test/smlc_line_model.sv ***
// far side model: modem receive data and a shared serial bus line
// assumes the bench plays clear-to-send; the line has a pull-up
`timescale 1ns/1ps
module smlc_line_model (
	input  wire logic clk,
	input  wire logic jam_a,
	input  wire logic oe_a,
	input  wire logic out_a,
	input  wire logic oe_b,
	input  wire logic out_b,
	output logic      sense_a,
	output logic      sense_b,
	output logic      rxd_a,
	output logic      rxd_b
);
	logic rx_q = 1'h0;

	// receive data flips every cycle, so a stale sample never matches
	always @(posedge clk) begin
		rx_q <= ~rx_q;
	end
	assign rxd_a = rx_q;
	assign rxd_b = ~rx_q;

	// bus line into collision sense
	// a released pin floats high; jam is another station pulling low
	assign sense_a = (oe_a ? out_a : 1'h1) & ~jam_a;
	assign sense_b = oe_b ? out_b : 1'h1;
endmodule

// *** test/smlc_top_monitor.sv ***
// port-level checker for the modem control block
// assumes one clock domain, MCLK, with NRST as its reset
`timescale 1ns/1ps
module smlc_top_monitor (
	input wire logic                      MCLK,
	input wire logic                      NRST,
	input wire logic                      RESET_INPUT_PIN,
	input wire logic                      WB_CYC_I,
	input wire logic                      WB_STB_I,
	input wire logic                      WB_ACK_O,
	input wire logic                      INT_O,
	input wire logic                      POWER_DOWN,
	input wire logic                      RTS_N_A,
	input wire logic                      RTS_N_B,
	input wire logic                      RECV_SERIAL_IN_A,
	input wire logic                      CTS_N_A,
	input wire logic                      COLLISION_SENSE_IN_A,
	input wire logic                      XMIT_SERIAL_OUT_A,
	input wire logic                      XMIT_SERIAL_OE_A,
	input wire smlc_pkg::smlc_frame_in_t  FRAME_IN_A,
	input wire smlc_pkg::smlc_frame_out_t FRAME_OUT_A
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	// request still waiting for its answer
	sequence s_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	// pin released after a normal, non-reset edge
	sequence s_released;
		!RESET_INPUT_PIN ##1 !XMIT_SERIAL_OE_A;
	endsequence
	// own bit high on a bus that another station pulls low
	sequence s_clash;
		$fell(COLLISION_SENSE_IN_A) && !XMIT_SERIAL_OE_A && FRAME_IN_A.tx_active;
	endsequence

	a_ack_follows: assert property (s_req |=> WB_ACK_O) else $error("ack late");
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	a_rx_follow: assert property (!RESET_INPUT_PIN |=>
		FRAME_OUT_A.rx_bit == $past(RECV_SERIAL_IN_A)) else $error("rx bit wrong");
	a_cts_gate: assert property (CTS_N_A |=> !FRAME_OUT_A.tx_enable)
		else $error("tx on without cts");
	a_reset_hold: assert property (RESET_INPUT_PIN |=>
		!POWER_DOWN && RTS_N_A && RTS_N_B && !INT_O) else $error("reset state wrong");
	a_pd_entry: assert property ($fell(RESET_INPUT_PIN) |-> ##[1:2] POWER_DOWN)
		else $error("no power down");
	a_od_release: assert property (s_released |-> !XMIT_SERIAL_OUT_A)
		else $error("released pin drives");
	a_coll_flag: assert property (s_clash |-> ##[1:2] FRAME_OUT_A.collision)
		else $error("collision missed");
endmodule

bind smlc_top smlc_top_monitor smlc_top_monitor_i (
	.MCLK(MCLK), .NRST(NRST), .RESET_INPUT_PIN(RESET_INPUT_PIN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
	.INT_O(INT_O), .POWER_DOWN(POWER_DOWN), .RTS_N_A(RTS_N_A), .RTS_N_B(RTS_N_B),
	.RECV_SERIAL_IN_A(RECV_SERIAL_IN_A), .CTS_N_A(CTS_N_A),
	.COLLISION_SENSE_IN_A(COLLISION_SENSE_IN_A), .XMIT_SERIAL_OUT_A(XMIT_SERIAL_OUT_A),
	.XMIT_SERIAL_OE_A(XMIT_SERIAL_OE_A), .FRAME_IN_A(FRAME_IN_A), .FRAME_OUT_A(FRAME_OUT_A)
);

// *** test/smlc_top_bench.sv ***
// self-checking bench for the two-channel modem control block
// assumes the line model on the far side; bench plays cts and frame engine
`timescale 1ns/1ps
`include "smlc_params.svh"
module smlc_top_bench;
	logic                      mclk = 1'h0;
	logic                      nrst = 1'h0;
	logic                      rst_pin = 1'h1;
	logic                      cyc = 1'h0;
	logic                      we = 1'h0;
	logic                      jam = 1'h0;
	logic                      cts_n_a = 1'h1;
	logic                      cts_n_b = 1'h1;
	logic [7:0]                adr = 8'h00;
	logic [3:0]                sel = 4'hF;
	logic [31:0]               wdat = 32'h0;
	smlc_pkg::smlc_frame_in_t  fa = 5'h00;
	smlc_pkg::smlc_frame_in_t  fb = 5'h00;
	smlc_pkg::smlc_frame_out_t fo_a, fo_b;
	logic [31:0]               rdat, q;
	logic                      ack, int_o, pd, rts_n_a, rts_n_b, rx_a, rx_b, sn_a, sn_b;
	logic                      out_a, out_b, oe_a, oe_b;
	int                        checks = 0;
	int                        fail_count = 0;

	// 200 MHz clock
	always #2.5 mclk = ~mclk;

	smlc_top smlc_top_i (
		.MCLK(mclk), .NRST(nrst), .RESET_INPUT_PIN(rst_pin), .WB_CYC_I(cyc),
		.WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .INT_O(int_o), .POWER_DOWN(pd),
		.RECV_SERIAL_IN_A(rx_a), .RECV_SERIAL_IN_B(rx_b), .CTS_N_A(cts_n_a),
		.CTS_N_B(cts_n_b), .COLLISION_SENSE_IN_A(sn_a), .COLLISION_SENSE_IN_B(sn_b),
		.RTS_N_A(rts_n_a), .RTS_N_B(rts_n_b), .XMIT_SERIAL_OUT_A(out_a),
		.XMIT_SERIAL_OUT_B(out_b), .XMIT_SERIAL_OE_A(oe_a), .XMIT_SERIAL_OE_B(oe_b),
		.FRAME_IN_A(fa), .FRAME_IN_B(fb), .FRAME_OUT_A(fo_a), .FRAME_OUT_B(fo_b)
	);

	smlc_line_model smlc_line_model_i (
		.clk(mclk), .jam_a(jam), .oe_a(oe_a), .out_a(out_a), .oe_b(oe_b), .out_b(out_b),
		.sense_a(sn_a), .sense_b(sn_b), .rxd_a(rx_a), .rxd_b(rx_b)
	);

	task automatic test_done();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask

	// settle a fixed count of edges, then look just after the last one
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// one classic cycle; the request stands until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, we, adr, wdat} <= {1'h1, w, a, d};
		@(posedge mclk);
		while (ack !== 1'h1 && n < 20) begin
			n++;
			@(posedge mclk);
		end
		q = rdat;
		cyc <= 1'h0;
		if (ack !== 1'h1) begin
			fail_count++;
			test_done();
		end
	endtask

	task automatic t_reset();
		rst_pin <= 1'h1;
		tk(`SMLC_RES_MIN_CYC);
		cmp("pd in reset", 1'h0, pd);
		cmp("irq in reset", 1'h0, int_o);
		@(posedge mclk);
		rst_pin <= 1'h0;
		tk(3);
		cmp("pd after reset", 1'h1, pd);
		wb(1'h0, 8'h04, 32'h0);
		cmp("cfg after reset", 32'h0, q);
		wb(1'h1, 8'h1C, 32'h1);
		tk(3);
		cmp("pd woken", 1'h0, pd);
		$display("t_reset done");
	endtask

	task automatic t_regs();
		wb(1'h0, 8'h20, 32'h0);
		cmp("unmapped", 32'h0, q);
		sel <= 4'hE;
		wb(1'h1, 8'h04, 32'h5);
		sel <= 4'hF;
		wb(1'h0, 8'h04, 32'h0);
		cmp("cfg lane off", 32'h0, q);
		wb(1'h0, 8'h18, 32'h0);
		cmp("line idle", 32'hF, q);
		$display("t_regs done");
	endtask

	task automatic t_rts_sw();
		wb(1'h1, 8'h00, 32'h1);
		tk(3);
		cmp("rts a set", 1'h0, rts_n_a);
		cmp("rts b apart", 1'h1, rts_n_b);
		@(posedge mclk);
		fa <= 5'h02;
		wb(1'h1, 8'h00, 32'h0);
		tk(3);
		cmp("rts a pending", 1'h0, rts_n_a);
		@(posedge mclk);
		fa <= 5'h00;
		tk(3);
		cmp("rts a free", 1'h1, rts_n_a);
		$display("t_rts_sw done");
	endtask

	task automatic t_rts_bus();
		wb(1'h1, 8'h0C, 32'h2);
		fb <= 5'h01;
		tk(3);
		cmp("rts rx frame", 1'h0, rts_n_b);
		@(posedge mclk);
		fb <= 5'h00;
		tk(3);
		cmp("rts rx idle", 1'h1, rts_n_b);
		wb(1'h1, 8'h0C, 32'h1);
		fb <= 5'h08;
		tk(40);
		cmp("rts tx frame", 1'h0, rts_n_b);
		@(posedge mclk);
		fb <= 5'h0C;
		tk(40);
		cmp("rts tx coll", 1'h1, rts_n_b);
		@(posedge mclk);
		fb <= 5'h00;
		wb(1'h1, 8'h0C, 32'h3);
		wb(1'h1, 8'h08, 32'h1);
		tk(3);
		cmp("rts disabled", 1'h1, rts_n_b);
		wb(1'h1, 8'h08, 32'h0);
		$display("t_rts_bus done");
	endtask

	task automatic t_cts();
		wb(1'h1, 8'h04, 32'h8);
		wb(1'h1, 8'h14, 32'h1);
		cts_n_a <= 1'h0;
		tk(3);
		cmp("cts fall irq", 1'h1, int_o);
		cmp("tx enabled", 1'h1, fo_a.tx_enable);
		wb(1'h0, 8'h10, 32'h0);
		cmp("status a only", 32'h1, q);
		wb(1'h1, 8'h10, 32'h1);
		tk(2);
		cmp("irq cleared", 1'h0, int_o);
		wb(1'h1, 8'h14, 32'h0);
		cts_n_a <= 1'h1;
		tk(3);
		cmp("irq masked", 1'h0, int_o);
		cmp("tx blocked", 1'h0, fo_a.tx_enable);
		wb(1'h0, 8'h10, 32'h0);
		cmp("cts rise sticky", 32'h1, q);
		wb(1'h1, 8'h10, 32'h1);
		$display("t_cts done");
	endtask

	task automatic t_drive();
		cts_n_a <= 1'h0;
		wb(1'h1, 8'h04, 32'h0);
		tk(3);
		cmp("push pull low", 2'h1, {out_a, oe_a});
		cmp("b pin idle", 2'h3, {out_b, oe_b});
		cmp("rx b own pin", {31'h0, ~rx_b}, fo_b.rx_bit);
		wb(1'h1, 8'h04, 32'h4);
		tk(3);
		cmp("open drain low", 2'h1, {out_a, oe_a});
		wb(1'h1, 8'h14, 32'h4);
		fa <= 5'h18;
		tk(3);
		cmp("open drain high", 2'h0, {out_a, oe_a});
		cmp("no false collision", 1'h0, int_o);
		@(posedge mclk);
		jam <= 1'h1;
		tk(3);
		cmp("collision irq", 1'h1, int_o);
		@(posedge mclk);
		jam <= 1'h0;
		fa <= 5'h00;
		wb(1'h0, 8'h10, 32'h0);
		// the cts fall at the start of this test also left its change bit set
		cmp("collision status", 32'h5, q);
		wb(1'h1, 8'h10, 32'h5);
		$display("t_drive done");
	endtask

	// reset for ten cycles, reset pin held on across it
	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'h1;
		t_reset();
		t_regs();
		t_rts_sw();
		t_rts_bus();
		t_cts();
		t_drive();
		// second reset pin pulse at the end of the run
		t_reset();
		test_done();
	end
endmodule
